// file: core/clock_comp_timer.sv
`timescale 1ns/10ps
`default_nettype none
module clock_comp_timer
  import stream_frame_pkg::*;
#(
  parameter int INTERVAL = CC_INTERVAL_CLKS,
  parameter int LEN      = CC_LEN_CLKS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // handshake with the framer
  input wire logic allow_in,
  output logic     active_out
);
  logic [CC_CNT_W-1:0] tick;
  logic [3:0]          run;
  logic                due;

  // free-running interval count, never stalls
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick <= '0;
    end else if (tick == CC_CNT_W'(INTERVAL - 1)) begin
      tick <= '0;
    end else begin
      tick <= tick + 1'b1;
    end
  end

  // due waits for a legal slot so the end tail is never split
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      due <= 1'b0;
    end else if (tick == CC_CNT_W'(INTERVAL - 1)) begin
      due <= 1'b1;
    end else if (due && allow_in && !active_out) begin
      due <= 1'b0;
    end
  end

  // sequence length in clocks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run        <= '0;
      active_out <= 1'b0;
    end else if (active_out) begin
      run        <= run + 1'b1;
      active_out <= (run != 4'(LEN - 1));
    end else if (due && allow_in) begin
      run        <= '0;
      active_out <= 1'b1;
    end
  end
endmodule : clock_comp_timer
`default_nettype wire

// file: core/frame_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // fill and drain sides
  stream_if.snk    wr,
  stream_if.src    rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty    = (wp == rp);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = mem[rp[AW-1:0]];
  assign push     = wr.valid & ~full;
  assign pop      = rd.ready & ~empty;

  // write pointer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp <= '0;
    end else if (push) begin
      wp <= wp + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rp <= '0;
    end else if (pop) begin
      rp <= rp + 1'b1;
    end
  end

  // storage needs no reset, empty flag guards it
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp[AW-1:0]] <= wr.data;
    end
  end
endmodule : frame_fifo
`default_nettype wire

// file: core/stream_frame_link_user_port.sv
`timescale 1ns/10ps
`default_nettype none
module stream_frame_link_user_port #(
  parameter bit LITTLE_ENDIAN = 1'b0,
  parameter int CC_INTERVAL   = stream_frame_pkg::CC_INTERVAL_CLKS
) (
  // clock and reset
  input wire logic                                 clk_in,
  input wire logic                                 rst_in,
  // transmit user stream
  input wire logic [stream_frame_pkg::DATA_W-1:0] tx_tdata_in,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] tx_tkeep_in,
  input wire logic                                 tx_tvalid_in,
  input wire logic                                 tx_tlast_in,
  output logic                                     tx_tready_out,
  // transmit channel toward the lanes
  output logic [stream_frame_pkg::DATA_W-1:0]     tx_chan_data_out,
  output logic [stream_frame_pkg::KEEP_W-1:0]     tx_chan_ctrl_out,
  // receive channel from the lanes
  input wire logic [stream_frame_pkg::DATA_W-1:0] rx_chan_data_in,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] rx_chan_ctrl_in,
  input wire logic                                 rx_chan_valid_in,
  // receive user stream, no ready
  output logic [stream_frame_pkg::DATA_W-1:0]     rx_tdata_out,
  output logic [stream_frame_pkg::KEEP_W-1:0]     rx_tkeep_out,
  output logic                                     rx_tvalid_out,
  output logic                                     rx_tlast_out
);
  import stream_frame_pkg::*;

  // ********************
  // transmit path
  // ********************
  localparam int PW = DATA_W + KEEP_W + 1;

  stream_if #(.W(PW)) fin ();
  stream_if #(.W(PW)) fout ();

  tx_state_t   tx_state;
  logic        gap;
  logic        cc_active;
  logic        open_in;
  logic        take;
  logic        allow;
  logic        f_last;
  logic [3:0]  f_keep;
  logic [31:0] f_data;
  logic [2:0]  cnt;
  logic [15:0] carry;
  logic [31:0] tail_word;
  logic [3:0]  tail_ctrl;
  logic [31:0] next_chan;
  logic [3:0]  next_ctrl;

  // entry closes in the end gap and during clock compensation
  assign open_in       = ~gap & ~cc_active;
  assign fin.data      = {tx_tlast_in, tx_tkeep_in, tx_tdata_in};
  assign fin.valid     = tx_tvalid_in & open_in;
  assign tx_tready_out = fin.ready & open_in;

  frame_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .wr     (fin),
    .rd     (fout)
  );

  // fifo head fields
  assign f_last = fout.data[PW-1];
  assign f_keep = fout.data[DATA_W +: KEEP_W];
  assign f_data = fout.data[DATA_W-1:0];
  assign cnt    = keep_count(f_keep, LITTLE_ENDIAN);

  // framer stalls the fifo, so back-pressure reaches the user
  assign fout.ready = (tx_state != TX_TAIL) & ~cc_active;
  assign take       = fout.valid & fout.ready;

  // clock compensation never cuts into an end tail
  assign allow = (tx_state != TX_TAIL) & ~(take & f_last);

  clock_comp_timer #(
    .INTERVAL (CC_INTERVAL),
    .LEN      (CC_LEN_CLKS)
  ) u_cc (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .allow_in   (allow),
    .active_out (cc_active)
  );

  // ready gap one cycle after the last beat is accepted
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gap <= 1'b0;
    end else begin
      gap <= tx_tvalid_in & tx_tready_out & tx_tlast_in;
    end
  end

  // frame state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_state <= TX_IDLE;
    end else if (take) begin
      tx_state <= f_last ? TX_TAIL : TX_DATA;
    end else if (tx_state == TX_TAIL) begin
      tx_state <= TX_IDLE;
    end
  end

  // low two bytes held over to the next channel word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      carry <= 16'h0000;
    end else if (take) begin
      carry <= f_data[15:0];
    end
  end

  // end tail: leftover bytes, pad or idles, then end marker on the right lane
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tail_word <= IDLE_WORD;
      tail_ctrl <= ALL_CTRL;
    end else if (take && f_last) begin
      case (cnt)
        3'h4: begin
          tail_word <= {f_data[15:0], END_HI, END_LO};
          tail_ctrl <= 4'h3;
        end
        3'h3: begin
          tail_word <= {f_data[15:8], PAD_CHAR, END_HI, END_LO};
          tail_ctrl <= 4'h7;
        end
        default: begin
          tail_word <= {IDLE_CHR, IDLE_CHR, END_HI, END_LO};
          tail_ctrl <= ALL_CTRL;
        end
      endcase
    end
  end

  // channel word choice; priority tail, then clock comp, then data
  always_comb begin
    next_chan = IDLE_WORD;
    next_ctrl = ALL_CTRL;
    case (1'b1)
      (tx_state == TX_TAIL): begin
        next_chan = tail_word;
        next_ctrl = tail_ctrl;
      end
      cc_active: begin
        next_chan = CC_WORD;
        next_ctrl = ALL_CTRL;
      end
      take: begin
        if (tx_state == TX_IDLE) begin
          next_chan = {START_HI, START_LO, f_data[31:16]};
          next_ctrl = 4'hC;
        end else begin
          next_chan = {carry, f_data[31:16]};
          next_ctrl = 4'h0;
        end
        if (f_last && cnt == 3'h1) begin
          next_chan[7:0] = PAD_CHAR;
          next_ctrl[0]   = 1'b1;
        end
      end
      default: begin
        next_chan = IDLE_WORD;
        next_ctrl = ALL_CTRL;
      end
    endcase
  end

  // registered channel output
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_chan_data_out <= IDLE_WORD;
      tx_chan_ctrl_out <= ALL_CTRL;
    end else begin
      tx_chan_data_out <= next_chan;
      tx_chan_ctrl_out <= next_ctrl;
    end
  end

  // ********************
  // receive path
  // ********************
  logic        in_frame;
  logic [7:0]  acc [0:2];
  logic [2:0]  acc_n;
  logic        pend;
  logic        start_here;
  logic        end_here;
  logic [7:0]  m [0:6];
  logic [2:0]  n;
  logic        emit;
  logic        emit_last;
  logic [2:0]  emit_n;
  logic [31:0] edata;
  logic [7:0]  next_acc [0:2];
  logic [2:0]  next_acc_n;
  logic        next_pend;

  // markers are only looked for in their own lane
  assign start_here = rx_chan_valid_in && rx_chan_ctrl_in[3:2] == 2'h3
                      && rx_chan_data_in[31:16] == {START_HI, START_LO};
  assign end_here   = rx_chan_valid_in && rx_chan_ctrl_in[1:0] == 2'h3
                      && rx_chan_data_in[15:0] == {END_HI, END_LO};

  // strip control bytes, left-align data into output words
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      m[i] = 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      next_acc[i] = 8'h00;
    end
    n          = 3'h0;
    emit       = 1'b0;
    emit_last  = 1'b0;
    emit_n     = 3'h0;
    edata      = 32'h0000_0000;
    next_acc_n = 3'h0;
    next_pend  = 1'b0;
    if (!pend) begin
      for (int i = 0; i < 3; i++) begin
        if (3'(i) < acc_n) begin
          m[n] = acc[i];
          n    = n + 3'h1;
        end
      end
    end
    // control bytes and anything outside a frame never reach the user
    for (int i = 0; i < 4; i++) begin
      if (rx_chan_valid_in && !rx_chan_ctrl_in[3-i] && (in_frame || start_here)) begin
        m[n] = rx_chan_data_in[31-8*i -: 8];
        n    = n + 3'h1;
      end
    end
    if (pend) begin
      // held-over final byte takes this slot; next frame only starts here
      emit      = 1'b1;
      emit_last = 1'b1;
      emit_n    = acc_n;
      edata     = {acc[0], acc[1], acc[2], 8'h00};
      for (int i = 0; i < 3; i++) begin
        next_acc[i] = m[i];
      end
      next_acc_n = (n > 3'h3) ? 3'h3 : n;
    end else if (n >= 3'h4 || (end_here && n != 3'h0)) begin
      emit  = 1'b1;
      edata = {m[0], m[1], m[2], m[3]};
      if (n <= 3'h4) begin
        emit_n    = n;
        emit_last = end_here;
      end else begin
        emit_n = 3'h4;
        for (int i = 0; i < 3; i++) begin
          next_acc[i] = m[i+4];
        end
        next_acc_n = n - 3'h4;
        next_pend  = end_here;
      end
    end else begin
      // short word: hold and show a gap to the user
      for (int i = 0; i < 3; i++) begin
        next_acc[i] = m[i];
      end
      next_acc_n = n;
    end
  end

  // frame tracking and byte accumulator
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame <= 1'b0;
      acc_n    <= 3'h0;
      pend     <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        acc[i] <= 8'h00;
      end
    end else begin
      if (end_here) begin
        in_frame <= 1'b0;
      end else if (start_here) begin
        in_frame <= 1'b1;
      end
      acc_n <= next_acc_n;
      pend  <= next_pend;
      for (int i = 0; i < 3; i++) begin
        acc[i] <= next_acc[i];
      end
    end
  end

  // user outputs; no ready, the user must take every beat
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_tvalid_out <= 1'b0;
      rx_tlast_out  <= 1'b0;
      rx_tdata_out  <= 32'h0000_0000;
      rx_tkeep_out  <= 4'h0;
    end else begin
      rx_tvalid_out <= emit;
      rx_tlast_out  <= emit_last;
      if (emit) begin
        rx_tdata_out <= edata;
        rx_tkeep_out <= count_keep(emit_n, LITTLE_ENDIAN);
      end
    end
  end
endmodule : stream_frame_link_user_port
`default_nettype wire

// file: shared/stream_frame_pkg.sv
// Functional notes
// - new frame: start marker in bytes 0-1, then first n-2 user bytes
// - last two bytes of each beat go out one cycle later in bytes 0-1
// - ready drops one cycle after last is taken; tail and end marker sent then
// - odd-length frame gets one pad character to complete the code group
// - valid low mid-frame pauses the frame; idles go out meanwhile
// - insert a 12-byte-per-lane clock-comp sequence every 10,000 bytes per lane
// - interval 5,000 clocks (2-byte lanes) or 2,500 (4-byte); stall 6 or 3
// - receive side has no buffer and no ready; user takes every beat
// - receive valid rises with the first word of each frame
// - receive last rises with the final full or partial word
// - receive keep counts valid bytes of the final word; only valid with last
// - receive valid may drop anywhere, due to stripping and left-alignment
// - start marker only in the left lane, end marker only in the right lane
// - gap between last data group and end marker is filled with idles
// - all bytes in two-byte groups; overhead four bytes, five when odd
// - little-endian option reverses keep bit order
// - a transmit beat is captured only when ready and valid are both high
// - receive strips idles, clock-comp, markers and pads from user data
// - data outside a frame is ignored
package stream_frame_pkg;

  // ********************
  // widths and depths
  // ********************
  localparam int DATA_W     = 32;
  localparam int KEEP_W     = 4;
  localparam int LANE_BYTES = 2;
  localparam int FIFO_DEPTH = 8;

  // ********************
  // channel code bytes
  // ********************
  localparam logic [7:0] START_HI = 8'h5C;
  localparam logic [7:0] START_LO = 8'hFB;
  localparam logic [7:0] END_HI   = 8'hFD;
  localparam logic [7:0] END_LO   = 8'hFE;
  localparam logic [7:0] PAD_CHAR = 8'h9C;
  localparam logic [7:0] IDLE_CHR = 8'hBC;
  localparam logic [7:0] CC_CHAR  = 8'hF7;

  // ********************
  // reset values and clock-comp word
  // ********************
  localparam logic [31:0] IDLE_WORD = {4{IDLE_CHR}};
  localparam logic [3:0]  ALL_CTRL  = 4'hF;
  localparam logic [31:0] CC_WORD   = {4{CC_CHAR}};

  // ********************
  // clock compensation timing
  // ********************
  localparam int CC_BYTES_PER_LANE = 12;
  localparam int CC_INTERVAL_2B    = 5000;
  localparam int CC_INTERVAL_4B    = 2500;
  localparam int CC_INTERVAL_CLKS  = (LANE_BYTES == 2) ? CC_INTERVAL_2B : CC_INTERVAL_4B;
  localparam int CC_LEN_CLKS       = CC_BYTES_PER_LANE / LANE_BYTES;
  localparam int CC_CNT_W          = 13;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_TAIL = 2'b10
  } tx_state_t;

  // keep order reversal for the little-endian build
  function automatic logic [3:0] flip4(input logic [3:0] k);
    return {k[0], k[1], k[2], k[3]};
  endfunction : flip4

  // valid byte count from a left-aligned keep
  function automatic logic [2:0] keep_count(input logic [3:0] keep, input logic le);
    logic [3:0] k;
    k = le ? flip4(keep) : keep;
    case (k)
      4'hF: return 3'h4;
      4'hE: return 3'h3;
      4'hC: return 3'h2;
      4'h8: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : keep_count

  // keep pattern from a valid byte count
  function automatic logic [3:0] count_keep(input logic [2:0] n, input logic le);
    logic [3:0] k;
    case (n)
      3'h4: k = 4'hF;
      3'h3: k = 4'hE;
      3'h2: k = 4'hC;
      3'h1: k = 4'h8;
      default: k = 4'h0;
    endcase
    return le ? flip4(k) : k;
  endfunction : count_keep

endpackage : stream_frame_pkg

// file: shared/stream_if.sv
`timescale 1ns/10ps
`default_nettype none
// payload with valid/ready between internal modules
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : stream_if
`default_nettype wire

// file: verification/stream_frame_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// frame port checker
// ********************
module stream_frame_props #(
  parameter int CC_INTERVAL = 40
) (
  // clock and reset
  input wire logic                                 clk_in,
  input wire logic                                 rst_in,
  // transmit user stream
  input wire logic [stream_frame_pkg::DATA_W-1:0] tx_tdata_in,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] tx_tkeep_in,
  input wire logic                                 tx_tvalid_in,
  input wire logic                                 tx_tlast_in,
  input wire logic                                 tx_tready_out,
  // lane side
  input wire logic [stream_frame_pkg::DATA_W-1:0] tx_chan_data_out,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] tx_chan_ctrl_out,
  input wire logic [stream_frame_pkg::DATA_W-1:0] rx_chan_data_in,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] rx_chan_ctrl_in,
  input wire logic                                 rx_chan_valid_in,
  // receive user stream
  input wire logic [stream_frame_pkg::DATA_W-1:0] rx_tdata_out,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] rx_tkeep_out,
  input wire logic                                 rx_tvalid_out,
  input wire logic                                 rx_tlast_out
);
  import stream_frame_pkg::*;
  logic        is_cc;
  logic        end_w;
  logic        take_last;
  logic        cc_q;
  logic [15:0] gap_cnt;
  // decoded channel words
  assign is_cc     = (tx_chan_data_out == CC_WORD) && (tx_chan_ctrl_out == ALL_CTRL);
  assign end_w     = (tx_chan_ctrl_out[1:0] == 2'b11) && (tx_chan_data_out[15:0] == {END_HI, END_LO});
  assign take_last = tx_tvalid_in && tx_tready_out && tx_tlast_in;
  // spacing of cc runs; slack allows for a deferred tail
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cc_q    <= 1'b0;
      gap_cnt <= 16'h0000;
    end else begin
      cc_q    <= is_cc;
      gap_cnt <= (is_cc && !cc_q) ? 16'h0000 : gap_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_cc_run;
    is_cc [*6] ##1 !is_cc;
  endsequence
  sequence s_end_word;
    end_w;
  endsequence
  a_ready_gap: assert property (take_last |=> !tx_tready_out)
    else $error("ready high after last");
  a_end_follows_last: assert property (take_last |-> ##[1:20] s_end_word)
    else $error("no end marker after last");
  a_start_left_lane: assert property (!((tx_chan_ctrl_out[1:0] == 2'b11) && (tx_chan_data_out[15:0] == {START_HI, START_LO})))
    else $error("start marker in right lane");
  a_end_right_lane: assert property (!((tx_chan_ctrl_out[3:2] == 2'b11) && (tx_chan_data_out[31:16] == {END_HI, END_LO})))
    else $error("end marker in left lane");
  a_pad_before_end: assert property ((end_w && tx_chan_ctrl_out[3:2] == 2'b01) |-> tx_chan_data_out[23:16] == PAD_CHAR)
    else $error("odd tail without pad");
  a_cc_run_len: assert property ($rose(is_cc) |-> s_cc_run)
    else $error("cc run length wrong");
  a_cc_spacing: assert property ($rose(is_cc) |-> gap_cnt >= 16'(CC_INTERVAL - 12) && gap_cnt <= 16'(CC_INTERVAL + 12))
    else $error("cc spacing wrong");
  a_rx_last_valid: assert property (rx_tlast_out |-> rx_tvalid_out)
    else $error("rx last without valid");
  a_rx_keep_shape: assert property ((rx_tvalid_out && rx_tlast_out) |-> rx_tkeep_out inside {4'hF, 4'hE, 4'hC, 4'h8})
    else $error("rx keep malformed");
  a_rx_keep_full: assert property ((rx_tvalid_out && !rx_tlast_out) |-> rx_tkeep_out == 4'hF)
    else $error("rx keep not full mid-frame");
endmodule : stream_frame_props
bind stream_frame_link_user_port stream_frame_props #(.CC_INTERVAL(CC_INTERVAL)) i_props (
  .clk_in(clk_in), .rst_in(rst_in), .tx_tdata_in(tx_tdata_in), .tx_tkeep_in(tx_tkeep_in),
  .tx_tvalid_in(tx_tvalid_in), .tx_tlast_in(tx_tlast_in), .tx_tready_out(tx_tready_out),
  .tx_chan_data_out(tx_chan_data_out), .tx_chan_ctrl_out(tx_chan_ctrl_out), .rx_chan_data_in(rx_chan_data_in),
  .rx_chan_ctrl_in(rx_chan_ctrl_in), .rx_chan_valid_in(rx_chan_valid_in), .rx_tdata_out(rx_tdata_out),
  .rx_tkeep_out(rx_tkeep_out), .rx_tvalid_out(rx_tvalid_out), .rx_tlast_out(rx_tlast_out));
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import stream_frame_pkg::*;
  localparam int CC_INT = 40;
  logic        clk_in, rst_in, slow;
  logic [31:0] tx_tdata, chan_data, rx_tdata;
  logic [3:0]  tx_tkeep, chan_ctrl, rx_tkeep;
  logic        tx_tvalid, tx_tlast, tx_tready, rx_tvalid, rx_tlast;
  logic [35:0] chan_q[$], exp_chan[$];
  logic [36:0] exp_rx[$];
  logic [7:0]  fill;
  int          err_total, n_tests, cyc, cc_words;
  // ********************
  // design and partner
  // ********************
  stream_frame_link_user_port #(.LITTLE_ENDIAN(1'b0), .CC_INTERVAL(CC_INT)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .tx_tdata_in(tx_tdata), .tx_tkeep_in(tx_tkeep), .tx_tvalid_in(tx_tvalid),
    .tx_tlast_in(tx_tlast), .tx_tready_out(tx_tready), .tx_chan_data_out(chan_data), .tx_chan_ctrl_out(chan_ctrl),
    .rx_chan_data_in(chan_data), .rx_chan_ctrl_in(chan_ctrl), .rx_chan_valid_in(1'b1), .rx_tdata_out(rx_tdata),
    .rx_tkeep_out(rx_tkeep), .rx_tvalid_out(rx_tvalid), .rx_tlast_out(rx_tlast));
  user_app_model i_app (
    .clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .tx_tdata_out(tx_tdata), .tx_tkeep_out(tx_tkeep),
    .tx_tvalid_out(tx_tvalid), .tx_tlast_out(tx_tlast), .tx_tready_in(tx_tready), .rx_tdata_in(rx_tdata),
    .rx_tkeep_in(rx_tkeep), .rx_tvalid_in(rx_tvalid), .rx_tlast_in(rx_tlast));
  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // channel monitor; idle and cc words carry no frame content
  always @(posedge clk_in) begin
    if (!rst_in && {chan_ctrl, chan_data} == {4'hF, CC_WORD}) cc_words++;
    else if (!rst_in && {chan_ctrl, chan_data} != {4'hF, IDLE_WORD}) chan_q.push_back({chan_ctrl, chan_data});
  end
  // hang guard, well above the whole sequence
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  // ********************
  // shared helpers
  // ********************
  task automatic add_frame(input int nb, input logic [3:0] keep);
    logic [7:0]  d[$];
    logic [8:0]  e[$];
    logic [31:0] w;
    int          n;
    @(posedge clk_in);
    n = (nb - 1) * 4 + ((keep == 4'hF) ? 4 : (keep == 4'hE) ? 3 : (keep == 4'hC) ? 2 : 1);
    for (int i = 0; i < nb * 4; i++) begin
      d.push_back((i < n) ? 8'h30 + fill : 8'hA5);
      fill++;
    end
    for (int b = 0; b < nb; b++) begin
      w = {d[4*b], d[4*b+1], d[4*b+2], d[4*b+3]};
      i_app.tx_q.push_back({b == nb - 1, (b == nb - 1) ? keep : 4'hF, w});
      exp_rx.push_back({b == nb - 1, (b == nb - 1) ? keep : 4'hF, w});
    end
    e = '{9'h15C, 9'h1FB};
    for (int i = 0; i < n; i++) e.push_back({1'b0, d[i]});
    if (n % 2) e.push_back({1'b1, PAD_CHAR});
    while (e.size() % 4 != 2) e.push_back({1'b1, IDLE_CHR});
    e.push_back({1'b1, END_HI});
    e.push_back({1'b1, END_LO});
    for (int i = 0; i < e.size(); i += 4)
      exp_chan.push_back({e[i][8], e[i+1][8], e[i+2][8], e[i+3][8], e[i][7:0], e[i+1][7:0], e[i+2][7:0], e[i+3][7:0]});
  endtask : add_frame
  task automatic check_all();
    logic [36:0] g;
    logic [31:0] m;
    for (int i = 0; i < 400 && i_app.rx_q.size() < exp_rx.size(); i++) @(posedge clk_in);
    repeat (4) @(posedge clk_in);
    `CHK(chan_q.size(), exp_chan.size())
    for (int i = 0; i < exp_chan.size() && i < chan_q.size(); i++) `CHK(chan_q[i], exp_chan[i])
    `CHK(i_app.rx_q.size(), exp_rx.size())
    for (int i = 0; i < exp_rx.size() && i < i_app.rx_q.size(); i++) begin
      g = i_app.rx_q[i];
      m = {{8{exp_rx[i][35]}}, {8{exp_rx[i][34]}}, {8{exp_rx[i][33]}}, {8{exp_rx[i][32]}}};
      `CHK(g[31:0] & m, exp_rx[i][31:0] & m)
      `CHK(g[36], exp_rx[i][36])
      if (exp_rx[i][36]) `CHK(g[35:32], exp_rx[i][35:32])
    end
    chan_q.delete();
    exp_chan.delete();
    i_app.rx_q.delete();
    exp_rx.delete();
  endtask : check_all
  // ********************
  // scenarios
  // ********************
  task automatic t_reset_values();
    `CHK(tx_tready, 1'b1)
    `CHK({chan_ctrl, chan_data}, {4'hF, IDLE_WORD})
    `CHK(rx_tvalid, 1'b0)
  endtask : t_reset_values
  task automatic t_keep_codes();
    logic [3:0] k[4] = '{4'hF, 4'hE, 4'hC, 4'h8};
    for (int i = 0; i < 4; i++) begin
      add_frame(3, k[i]);
      check_all();
    end
  endtask : t_keep_codes
  task automatic t_single_beat();
    add_frame(1, 4'h8);
    add_frame(1, 4'hF);
    check_all();
  endtask : t_single_beat
  task automatic t_back_to_back();
    add_frame(2, 4'hE);
    add_frame(3, 4'hF);
    add_frame(1, 4'hC);
    check_all();
  endtask : t_back_to_back
  task automatic t_paused();
    @(negedge clk_in);
    slow = 1'b1;
    add_frame(4, 4'hE);
    check_all();
    @(negedge clk_in);
    slow = 1'b0;
  endtask : t_paused
  task automatic t_cc_long();
    cc_words = 0;
    add_frame(12, 4'h8);
    add_frame(9, 4'hC);
    check_all();
    `CHK(cc_words != 0, 1'b1)
  endtask : t_cc_long
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    rst_in = 1'b1;
    slow = 1'b0;
    fill = 8'h00;
    {err_total, n_tests, cyc, cc_words} = '0;
    repeat (2) @(negedge clk_in);
    t_reset_values();
    rst_in = 1'b0;
    t_keep_codes();
    t_single_beat();
    t_back_to_back();
    t_paused();
    t_cc_long();
    final_report();
  end
endmodule : testbench
`default_nettype wire

// file: verification/user_app_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// user application model
// ********************
module user_app_model (
  // clock, reset, pacing
  input wire logic                                 clk_in,
  input wire logic                                 rst_in,
  input wire logic                                 slow_in,
  // transmit stream toward the port
  output logic [stream_frame_pkg::DATA_W-1:0]     tx_tdata_out,
  output logic [stream_frame_pkg::KEEP_W-1:0]     tx_tkeep_out,
  output logic                                     tx_tvalid_out,
  output logic                                     tx_tlast_out,
  input wire logic                                 tx_tready_in,
  // receive stream, always accepted
  input wire logic [stream_frame_pkg::DATA_W-1:0] rx_tdata_in,
  input wire logic [stream_frame_pkg::KEEP_W-1:0] rx_tkeep_in,
  input wire logic                                 rx_tvalid_in,
  input wire logic                                 rx_tlast_in
);
  import stream_frame_pkg::*;
  typedef struct packed {logic last; logic [3:0] keep; logic [31:0] data;} beat_t;
  beat_t tx_q[$];
  beat_t rx_q[$];
  logic  took;
  int    hold;
  initial begin
    {tx_tdata_out, tx_tkeep_out, tx_tvalid_out, tx_tlast_out} = '0;
    took = 1'b0;
    hold = 0;
  end
  // handshake and rx capture at the rising edge; no way to refuse a beat
  always @(posedge clk_in) begin
    took = tx_tvalid_out && tx_tready_in;
    if (rx_tvalid_in) rx_q.push_back({rx_tlast_in, rx_tkeep_in, rx_tdata_in});
  end
  // a beat is held until taken; slow mode idles between beats
  always @(negedge clk_in) begin
    if (took) begin
      void'(tx_q.pop_front());
      hold = slow_in ? 2 : 0;
    end
    // valid is written once per step: either the next beat or a pause
    if (took || !tx_tvalid_out) begin
      if (hold == 0 && !rst_in && tx_q.size() > 0) begin
        {tx_tlast_out, tx_tkeep_out, tx_tdata_out, tx_tvalid_out} = {tx_q[0], 1'b1};
      end else begin
        if (hold > 0) hold--;
        tx_tvalid_out = 1'b0;
        tx_tdata_out  = ~tx_tdata_out;
      end
    end
  end
endmodule : user_app_model
`default_nettype wire
